// *** include/dpc_params.svh ***
// Named constants for the digital potentiometer control and tolerance block.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// Command opcodes, upper nibble of the serial command word.
`define DPC_OP_NOP        4'h0
`define DPC_OP_WR_WIPER   4'h1
`define DPC_OP_READBACK   4'h3
`define DPC_OP_STEP       4'h4
`define DPC_OP_COPY_NV    4'h7
`define DPC_OP_WR_NVM     4'h8
`define DPC_OP_SCALE      4'h9
`define DPC_OP_WR_CTRL    4'hD

// Address nibble decode.
`define DPC_ADDR_WB       4'h0
`define DPC_ADDR_AW       4'h4
`define DPC_ADDR_ALL_BIT  3

// Nonvolatile memory map.
`define DPC_NV_WB         2'h0
`define DPC_NV_AW         2'h1
`define DPC_NV_TOL_INT    2'h2
`define DPC_NV_TOL_FRAC   2'h3
`define DPC_NV_DEPTH      4

// Readback selector in the low data bits.
`define DPC_RB_NVM        2'h1
`define DPC_RB_CTRL       2'h2
`define DPC_RB_WIPER      2'h3

// Data bit positions inside commands.
`define DPC_STEP_UP_BIT   0
`define DPC_COPY_STORE_BIT 0
`define DPC_SCALE_TOP_BIT 7
`define DPC_SCALE_ON_BIT  0

// Burst enable position in the control write data.
`define DPC_CTRL_BURST_BIT 3

// Control register reset: write enabled, store enabled, pot mode, burst off.
`define DPC_CTRL_RESET    4'h3

// Tolerance byte field positions.
`define DPC_TOL_SIGN_BIT  7

`endif

// *** include/dpc_pkg.sv ***
// Types shared by the digital potentiometer control and tolerance block.
`default_nettype none
package dpc_pkg;

	// One decoded serial command from the interface decoder.
	typedef struct packed {
		logic       valid;
		logic [3:0] op;
		logic [3:0] addr;
		logic [7:0] data;
	} dpc_cmd_type;

	// Control register, bit 3 down to bit 0.
	typedef struct packed {
		logic burst_en;
		logic linear_mode;
		logic nvm_prog_en;
		logic wiper_wr_en;
	} dpc_ctrl_type;

endpackage : dpc_pkg
`default_nettype wire

// *** src/dpc_core.sv ***
// Control register, wiper registers, nonvolatile store and tolerance bytes.
//
// Functional notes
// - Clear write protect bit freezes wiper to stored.
// - Store bit low blocks all nonvolatile writes.
// - Mode bit selects potentiometer or linear gain.
// - Burst bit keeps burst past stop/restart.
// - Seven or eight bit code selects one tap.
// - Pot mode: B side rises, A falls.
// - Linear mode: A side follows own code.
// - Top and bottom scale extra positions.
// - Tolerance held read-only as sixteen bits.
// - Address two: sign bit seven, integer below.
// - Address three: fraction, bit seven is half.
// - Logic supply rise reloads stored wiper values.
`default_nettype none
`include "dpc_params.svh"
module dpc_core #(
	parameter int                    WIPER_W      = 8,
	parameter logic [WIPER_W-1:0]    NV_WB_INIT   = 8'h80,
	parameter logic [WIPER_W-1:0]    NV_AW_INIT   = 8'h80,
	parameter logic [7:0]            TOL_SIGN_INT = 8'h80,
	parameter logic [7:0]            TOL_FRAC     = 8'h00
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire dpc_pkg::dpc_cmd_type cmd_i,
	input  wire logic                 bus_stop_i,
	input  wire logic                 logic_pwr_ok_i,
	output dpc_pkg::dpc_ctrl_type     ctrl_o,
	output logic      [WIPER_W-1:0]   wiper_code_register_o,
	output logic      [WIPER_W-1:0]   aw_code_o,
	output logic      [WIPER_W:0]     wiper_to_b_steps_o,
	output logic      [WIPER_W:0]     a_to_wiper_steps_o,
	output logic                      top_scale_o,
	output logic                      bottom_scale_o,
	output logic                      burst_active_o,
	output logic      [7:0]           rd_data_o,
	output logic                      rd_valid_o,
	output logic                      nvm_busy_o
);

	localparam logic [WIPER_W-1:0] CODE_MAX = '1;

	// Register state.
	dpc_pkg::dpc_ctrl_type ctrl_r;
	logic [WIPER_W-1:0]    wb_r;
	logic [WIPER_W-1:0]    aw_r;
	logic                  top_r;
	logic                  bottom_r;
	logic [7:0]            nvm_r [`DPC_NV_DEPTH];
	logic                  pwr_meta_r;
	logic                  pwr_sync_r;
	logic                  pwr_prev_r;
	logic                  preset;
	logic                  wiper_cmd;
	logic                  sel_aw;
	logic                  sel_all;
	logic [WIPER_W:0]      wb_steps;
	logic [WIPER_W:0]      aw_steps;
	logic [WIPER_W-1:0]    cmd_code;

	// Saturating one-step move of a wiper code.
	function automatic logic [WIPER_W-1:0] step_code(input logic [WIPER_W-1:0] code,
		input logic up);
		logic [WIPER_W-1:0] res;
		res = code;
		if (up && code != CODE_MAX) begin
			res = code + WIPER_W'(1);
		end else if (!up && code != '0) begin
			res = code - WIPER_W'(1);
		end
		return res;
	endfunction : step_code

	// Stored byte truncated to the wiper width.
	function automatic logic [WIPER_W-1:0] nv_code(input logic [7:0] b);
		return b[WIPER_W-1:0];
	endfunction : nv_code

	// The supply-good level comes from outside, so it is synchronised first.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pwr_meta_r <= 1'b0;
			pwr_sync_r <= 1'b0;
			pwr_prev_r <= 1'b0;
		end else begin
			pwr_meta_r <= logic_pwr_ok_i;
			pwr_sync_r <= pwr_meta_r;
			pwr_prev_r <= pwr_sync_r;
		end
	end

	assign preset = pwr_sync_r & ~pwr_prev_r;

	// Command decode shared by the wiper processes.
	assign cmd_code  = cmd_i.data[WIPER_W-1:0];
	assign sel_all   = cmd_i.addr[`DPC_ADDR_ALL_BIT];
	assign sel_aw    = cmd_i.addr == `DPC_ADDR_AW;
	assign wiper_cmd = cmd_i.valid & ctrl_r.wiper_wr_en;

	// Control register; only the dedicated command changes it.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_r <= dpc_pkg::dpc_ctrl_type'(`DPC_CTRL_RESET);
		end else if (cmd_i.valid && cmd_i.op == `DPC_OP_WR_CTRL) begin
			ctrl_r <= dpc_pkg::dpc_ctrl_type'(cmd_i.data[3:0]);
		end
	end

	// Wiper-to-B code, the main wiper register.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wb_r <= NV_WB_INIT;
		end else if (preset) begin
			wb_r <= nv_code(nvm_r[`DPC_NV_WB]);
		end else if (!ctrl_r.wiper_wr_en) begin
			wb_r <= nv_code(nvm_r[`DPC_NV_WB]);
		end else if (wiper_cmd && (sel_all || !sel_aw)) begin
			case (cmd_i.op)
				`DPC_OP_WR_WIPER: wb_r <= cmd_code;
				`DPC_OP_STEP:     wb_r <= step_code(wb_r, cmd_i.data[`DPC_STEP_UP_BIT]);
				`DPC_OP_COPY_NV: begin
					if (!cmd_i.data[`DPC_COPY_STORE_BIT]) begin
						wb_r <= nv_code(nvm_r[`DPC_NV_WB]);
					end
				end
				default:          wb_r <= wb_r;
			endcase
		end
	end

	// A-to-wiper code, used only in linear gain mode.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			aw_r <= NV_AW_INIT;
		end else if (preset) begin
			aw_r <= nv_code(nvm_r[`DPC_NV_AW]);
		end else if (!ctrl_r.wiper_wr_en) begin
			aw_r <= nv_code(nvm_r[`DPC_NV_AW]);
		end else if (wiper_cmd && ctrl_r.linear_mode && (sel_all || sel_aw)) begin
			case (cmd_i.op)
				`DPC_OP_WR_WIPER: aw_r <= cmd_code;
				`DPC_OP_STEP:     aw_r <= step_code(aw_r, cmd_i.data[`DPC_STEP_UP_BIT]);
				default:          aw_r <= aw_r;
			endcase
		end
	end

	// Top and bottom scale; a wiper write, step or supply-rise reload leaves them, a recall command from the store does not.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || preset || !ctrl_r.wiper_wr_en) begin
			top_r    <= 1'b0;
			bottom_r <= 1'b0;
		end else if (wiper_cmd && cmd_i.op == `DPC_OP_SCALE) begin
			if (cmd_i.data[`DPC_SCALE_TOP_BIT]) begin
				top_r    <= cmd_i.data[`DPC_SCALE_ON_BIT];
				bottom_r <= 1'b0;
			end else begin
				bottom_r <= cmd_i.data[`DPC_SCALE_ON_BIT];
				top_r    <= 1'b0;
			end
		end else if (wiper_cmd && (cmd_i.op == `DPC_OP_WR_WIPER || cmd_i.op == `DPC_OP_STEP)) begin
			top_r    <= 1'b0;
			bottom_r <= 1'b0;
		end
	end

	// Nonvolatile store. Tolerance bytes are never written, so they stay factory values.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			nvm_r[`DPC_NV_WB] <= 8'(NV_WB_INIT);
			nvm_r[`DPC_NV_AW] <= 8'(NV_AW_INIT);
			nvm_r[`DPC_NV_TOL_INT]  <= TOL_SIGN_INT;
			nvm_r[`DPC_NV_TOL_FRAC] <= TOL_FRAC;
		end else if (cmd_i.valid && ctrl_r.nvm_prog_en) begin
			if (cmd_i.op == `DPC_OP_WR_NVM && cmd_i.addr[3:1] == 3'h0) begin
				nvm_r[cmd_i.addr[1:0]] <= cmd_i.data;
			end else if (cmd_i.op == `DPC_OP_COPY_NV && cmd_i.data[`DPC_COPY_STORE_BIT]) begin
				if (sel_aw) begin
					nvm_r[`DPC_NV_AW] <= 8'(aw_r);
				end else begin
					nvm_r[`DPC_NV_WB] <= 8'(wb_r);
				end
			end
		end
	end

	// One-cycle store-in-progress flag so a host can see the store was taken.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			nvm_busy_o <= 1'b0;
		end else begin
			nvm_busy_o <= cmd_i.valid && ctrl_r.nvm_prog_en &&
				((cmd_i.op == `DPC_OP_WR_NVM && cmd_i.addr[3:1] == 3'h0) ||
				(cmd_i.op == `DPC_OP_COPY_NV && cmd_i.data[`DPC_COPY_STORE_BIT]));
		end
	end

	// Readback; the answer arrives one cycle after the command.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= 8'h00;
		end else begin
			rd_valid_o <= cmd_i.valid && cmd_i.op == `DPC_OP_READBACK;
			if (cmd_i.valid && cmd_i.op == `DPC_OP_READBACK) begin
				case (cmd_i.data[1:0])
					`DPC_RB_NVM:   rd_data_o <= nvm_r[cmd_i.addr[1:0]];
					`DPC_RB_CTRL:  rd_data_o <= {4'h0, ctrl_r};
					`DPC_RB_WIPER: rd_data_o <= sel_aw ? 8'(aw_r) : 8'(wb_r);
					default:       rd_data_o <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			burst_active_o <= 1'b0;
		end else if (cmd_i.valid && cmd_i.op == `DPC_OP_WR_CTRL) begin
			burst_active_o <= cmd_i.data[`DPC_CTRL_BURST_BIT];
		end else if (bus_stop_i && !ctrl_r.burst_en) begin
			burst_active_o <= 1'b0;
		end else if (ctrl_r.burst_en) begin
			burst_active_o <= 1'b1;
		end
	end

	dpc_tap_decoder #(
		.WIPER_W (WIPER_W)
	) u_taps (
		.wb_code_i      (wb_r),
		.aw_code_i      (aw_r),
		.linear_mode_i  (ctrl_r.linear_mode),
		.top_scale_i    (top_r),
		.bottom_scale_i (bottom_r),
		.wb_steps_o     (wb_steps),
		.aw_steps_o     (aw_steps)
	);

	// Registered copies so every output leaves from a flip-flop.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_o                <= dpc_pkg::dpc_ctrl_type'(`DPC_CTRL_RESET);
			wiper_code_register_o <= NV_WB_INIT;
			aw_code_o             <= NV_AW_INIT;
			wiper_to_b_steps_o    <= {1'b0, NV_WB_INIT};
			a_to_wiper_steps_o    <= (WIPER_W+1)'(1 << WIPER_W) - {1'b0, NV_WB_INIT};
			top_scale_o           <= 1'b0;
			bottom_scale_o        <= 1'b0;
		end else begin
			ctrl_o                <= ctrl_r;
			wiper_code_register_o <= wb_r;
			aw_code_o             <= aw_r;
			wiper_to_b_steps_o    <= wb_steps;
			a_to_wiper_steps_o    <= aw_steps;
			top_scale_o           <= top_r;
			bottom_scale_o        <= bottom_r;
		end
	end

endmodule : dpc_core
`default_nettype wire

// *** src/dpc_tap_decoder.sv ***
// Decoder from wiper codes and scale state to resistor string tap counts.
`default_nettype none
module dpc_tap_decoder #(
	parameter int WIPER_W = 8
) (
	input  wire logic [WIPER_W-1:0] wb_code_i,
	input  wire logic [WIPER_W-1:0] aw_code_i,
	input  wire logic               linear_mode_i,
	input  wire logic               top_scale_i,
	input  wire logic               bottom_scale_i,
	output logic      [WIPER_W:0]   wb_steps_o,
	output logic      [WIPER_W:0]   aw_steps_o
);

	localparam logic [WIPER_W:0] FULL = (WIPER_W+1)'(1 << WIPER_W);

	// Steps from wiper to B and from A to wiper, each in units of one LSB.
	always_comb begin
		wb_steps_o = {1'b0, wb_code_i};
		aw_steps_o = FULL - {1'b0, wb_code_i};
		if (linear_mode_i) begin
			aw_steps_o = {1'b0, aw_code_i};
		end
		if (bottom_scale_i) begin
			wb_steps_o = '0;
			aw_steps_o = linear_mode_i ? '0 : FULL;
		end else if (top_scale_i) begin
			// One LSB beyond the full code removes the last A-side step.
			wb_steps_o = FULL;
			aw_steps_o = '0;
		end
	end

endmodule : dpc_tap_decoder
`default_nettype wire

// *** test/dpc_core_properties.sv ***
// Port-level assertions for the control and tolerance block.
`default_nettype none
module dpc_core_properties #(
	parameter int         WIPER_W      = 8,
	parameter logic [7:0] TOL_SIGN_INT = 8'h80,
	parameter logic [7:0] TOL_FRAC     = 8'h00
) (
	input wire logic                  sys_clk_i,
	input wire logic                  sys_rst_i,
	input wire dpc_pkg::dpc_cmd_type  cmd_i,
	input wire dpc_pkg::dpc_ctrl_type ctrl_o,
	input wire logic [WIPER_W-1:0]    wiper_code_register_o,
	input wire logic [WIPER_W-1:0]    aw_code_o,
	input wire logic [WIPER_W:0]      wiper_to_b_steps_o,
	input wire logic [WIPER_W:0]      a_to_wiper_steps_o,
	input wire logic                  top_scale_o,
	input wire logic                  bottom_scale_o,
	input wire logic                  burst_active_o,
	input wire logic [7:0]            rd_data_o,
	input wire logic                  rd_valid_o,
	input wire logic                  nvm_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic rd_nv;
	logic flat;
	logic ctl_wr;
	// Scale states move both tap counts, so steady checks wait until neither scale is set.
	assign rd_nv = cmd_i.valid && cmd_i.op == 4'h3 && cmd_i.data[1:0] == 2'h1;
	assign flat = !top_scale_o && !bottom_scale_o;
	assign ctl_wr = cmd_i.valid && cmd_i.op == 4'hD;
	AST_RD_PULSE: assert property (cmd_i.valid && cmd_i.op == 4'h3 |=> rd_valid_o)
		else $error("readback without valid pulse");
	AST_TOL_HIGH: assert property (rd_nv && cmd_i.addr == 4'h2 |=> rd_data_o == TOL_SIGN_INT)
		else $error("sign and integer byte wrong");
	AST_TOL_LOW: assert property (rd_nv && cmd_i.addr == 4'h3 |=> rd_data_o == TOL_FRAC)
		else $error("fraction byte wrong");
	// Stores stay legal under protection and the wiper follows them, so store cycles are skipped.
	AST_FROZEN: assert property ((!ctrl_o.wiper_wr_en && !nvm_busy_o) [*3]
		|-> $stable(wiper_code_register_o))
		else $error("wiper moved while protected");
	AST_STORE_GATE: assert property (nvm_busy_o |-> ctrl_o.nvm_prog_en)
		else $error("store accepted while disabled");
	AST_POT: assert property ((!ctrl_o.linear_mode && flat) [*2]
		|-> wiper_to_b_steps_o + a_to_wiper_steps_o == (1 << WIPER_W))
		else $error("pot mode sides not complementary");
	AST_LINEAR: assert property ((ctrl_o.linear_mode && flat) [*2]
		|-> a_to_wiper_steps_o == {1'b0, aw_code_o})
		else $error("linear A side not following own code");
	AST_TAP: assert property (flat [*2]
		|-> wiper_to_b_steps_o == {1'b0, wiper_code_register_o})
		else $error("tap count differs from code");
	AST_TOP: assert property (top_scale_o [*2]
		|-> wiper_to_b_steps_o == (1 << WIPER_W) && a_to_wiper_steps_o == 0)
		else $error("top scale taps wrong");
	// A control write in this cycle may legally drop burst at the next edge.
	AST_BURST: assert property (burst_active_o && ctrl_o.burst_en && !ctl_wr
		|=> burst_active_o)
		else $error("burst dropped while enabled");
	COV_READ: cover property (rd_valid_o);
	COV_TOP: cover property (top_scale_o);
	COV_STORE: cover property (nvm_busy_o);
endmodule : dpc_core_properties
bind dpc_core dpc_core_properties #(.WIPER_W(WIPER_W), .TOL_SIGN_INT(TOL_SIGN_INT),
	.TOL_FRAC(TOL_FRAC)) u_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_i),
	.ctrl_o(ctrl_o), .wiper_code_register_o(wiper_code_register_o), .aw_code_o(aw_code_o),
	.wiper_to_b_steps_o(wiper_to_b_steps_o), .a_to_wiper_steps_o(a_to_wiper_steps_o),
	.top_scale_o(top_scale_o), .bottom_scale_o(bottom_scale_o),
	.burst_active_o(burst_active_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
	.nvm_busy_o(nvm_busy_o));
`default_nettype wire

// *** test/dpc_core_tb.sv ***
// Self-checking bench for the control and tolerance block.
`default_nettype none
module dpc_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  sys_clk;
	logic                  sys_rst;
	logic                  stop;
	logic                  pwr_ok;
	logic                  rd_valid;
	logic                  busy;
	logic                  top;
	logic                  bot;
	logic                  burst;
	logic [7:0]            wiper;
	logic [7:0]            rd_data;
	logic [8:0]            wb_steps;
	logic [8:0]            aw_steps;
	dpc_pkg::dpc_cmd_type  cmd;
	dpc_pkg::dpc_ctrl_type ctrl;
	int                    fail_count = 0;
	int                    cmp_count = 0;
	// Clock at 50 MHz.
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	dpc_host_model host (.sys_clk_i(sys_clk), .cmd_o(cmd), .stop_o(stop), .pwr_ok_o(pwr_ok));
	dpc_core #(.TOL_SIGN_INT(8'h02), .TOL_FRAC(8'hB0)) DUT (.sys_clk_i(sys_clk),
		.sys_rst_i(sys_rst), .cmd_i(cmd), .bus_stop_i(stop), .logic_pwr_ok_i(pwr_ok),
		.ctrl_o(ctrl), .wiper_code_register_o(wiper), .aw_code_o(),
		.wiper_to_b_steps_o(wb_steps), .a_to_wiper_steps_o(aw_steps), .top_scale_o(top),
		.bottom_scale_o(bot), .burst_active_o(burst), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .nvm_busy_o(busy));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// Returns once the edge that takes the command has landed.
	task automatic go(input logic [3:0] op, input logic [3:0] adr, input logic [7:0] dat);
		host.send(op, adr, dat);
		#1;
	endtask : go
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic rd(input logic [3:0] adr, input logic [7:0] sel, input logic [7:0] exp);
		go(4'h3, adr, sel);
		check(rd_valid, 1'b1);
		check(rd_data, exp);
		// The valid flag stands for one cycle only.
		settle(1);
		check(rd_valid, 1'b0);
	endtask : rd
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// A hung handshake must still reach the verdict.
	initial begin
		repeat (3000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		check(ctrl, 4'h3);
		check(aw_steps, 9'h080);
		rd(4'h0, 8'h02, 8'h03);
		rd(4'h2, 8'h01, 8'h02);
		rd(4'h3, 8'h01, 8'hB0);
		$display("done: defaults and tolerance");
		for (int i = 0; i < 3; i++) begin
			logic [7:0] c;
			c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h40;
			go(4'h1, 4'h0, c);
			settle(1);
			check(wb_steps, {1'b0, c});
			check(aw_steps, 9'h100 - {1'b0, c});
		end
		go(4'h7, 4'h0, 8'h01);
		check(busy, 1'b1);
		rd(4'h0, 8'h01, 8'h40);
		$display("done: codes and store");
		go(4'h9, 4'h0, 8'h81);
		settle(1);
		check({top, wb_steps, aw_steps}, {1'b1, 9'h100, 9'h000});
		go(4'h9, 4'h0, 8'h01);
		settle(1);
		check({bot, wb_steps, aw_steps}, {1'b1, 9'h000, 9'h100});
		go(4'h9, 4'h0, 8'h00);
		go(4'hD, 4'h0, 8'h07);
		go(4'h1, 4'h4, 8'h20);
		settle(1);
		check({wb_steps, aw_steps}, {9'h040, 9'h020});
		go(4'hD, 4'h0, 8'h03);
		$display("done: scales and linear mode");
		go(4'h1, 4'h0, 8'h55);
		go(4'hD, 4'h0, 8'h02);
		settle(2);
		check(wiper, 8'h40);
		go(4'h1, 4'h0, 8'h11);
		settle(2);
		check(wiper, 8'h40);
		go(4'hD, 4'h0, 8'h01);
		go(4'h1, 4'h0, 8'h22);
		settle(1);
		check(wiper, 8'h22);
		go(4'h7, 4'h0, 8'h01);
		check(busy, 1'b0);
		rd(4'h0, 8'h01, 8'h40);
		$display("done: protection");
		go(4'hD, 4'h0, 8'h09);
		host.stop_pulse();
		settle(2);
		check(burst, 1'b1);
		host.power_cycle();
		settle(5);
		check(wiper, 8'h40);
		$display("done: burst and preset");
		complete_run();
	end
endmodule : dpc_core_tb
`default_nettype wire

// *** test/dpc_host_model.sv ***
// Host controller model issuing decoded commands, stop conditions and supply steps.
`default_nettype none
module dpc_host_model (
	input  wire logic           sys_clk_i,
	output dpc_pkg::dpc_cmd_type cmd_o,
	output logic                stop_o,
	output logic                pwr_ok_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle fields after each command are inverted so a stale command never passes for a fresh one; the first idle word is all zero.
	initial begin
		cmd_o = '0;
		stop_o = 1'b0;
		pwr_ok_o = 1'b1;
	end
	task automatic send(input logic [3:0] op, input logic [3:0] adr, input logic [7:0] dat);
		@(posedge sys_clk_i);
		cmd_o <= {1'b1, op, adr, dat};
		@(posedge sys_clk_i);
		cmd_o <= {1'b0, ~op, ~adr, ~dat};
	endtask : send
	task automatic stop_pulse;
		@(posedge sys_clk_i);
		stop_o <= 1'b1;
		@(posedge sys_clk_i);
		stop_o <= 1'b0;
	endtask : stop_pulse
	task automatic power_cycle;
		@(posedge sys_clk_i);
		pwr_ok_o <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		pwr_ok_o <= 1'b1;
	endtask : power_cycle
endmodule : dpc_host_model
`default_nettype wire
